// >>> verilog/ilo_pkg.sv
// Shared constants for the indexed literal offset operand decoder.
// Assumes a single core clock and an 8-bit data path into a 4096-byte data space.
package ilo_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam int INSTR_W = 16;
    localparam int BANK_W = 4;
    localparam int REG_ADDR_W = 3;
    localparam int FLAG_W = 5;

    // Register port offsets.
    localparam logic [REG_ADDR_W-1:0] REG_CFG = 3'h0;
    localparam logic [REG_ADDR_W-1:0] REG_FSR_LO = 3'h1;
    localparam logic [REG_ADDR_W-1:0] REG_FSR_HI = 3'h2;
    localparam logic [REG_ADDR_W-1:0] REG_BANK_SEL = 3'h3;
    localparam logic [REG_ADDR_W-1:0] REG_WORK = 3'h4;
    localparam logic [REG_ADDR_W-1:0] REG_STATUS = 3'h5;

    // Reset values.
    localparam logic EXT_EN_RESET = 1'b0;
    localparam logic [ADDR_W-1:0] FSR_RESET = 12'h000;
    localparam logic [BANK_W-1:0] BANK_SEL_RESET = 4'h0;
    localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 5'h00;

    // Address decoding.
    localparam logic [DATA_W-1:0] OFFSET_MAX = 8'h5F;
    localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hF;

    // Opcode fields.
    localparam int A_BIT = 8;
    localparam int D_BIT = 9;
    localparam int BIT_IDX_LSB = 9;
    localparam int BIT_IDX_W = 3;
    localparam int OPC_ADD_LSB = 10;
    localparam int OPC_BSET_LSB = 12;
    localparam int OPC_SET_LSB = 9;
    localparam int NIBBLE_W = 4;
    localparam int CFG_EXT_BIT = 0;
    localparam logic [5:0] OPC_ADD_WORK_MEM = 6'h09;
    localparam logic [3:0] OPC_MEM_BIT_SET = 4'h8;
    localparam logic [6:0] OPC_MEM_SET_ONES = 7'h34;
    localparam logic [DATA_W-1:0] ALL_ONES = 8'hFF;

    // Status flag positions.
    localparam int FLAG_C = 0;
    localparam int FLAG_DIGIT_C = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OVFL = 3;
    localparam int FLAG_N = 4;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_EXEC = 2'b10
    } state_t;
endpackage

// >>> verilog/addr_resolve.sv
// Resolves the file address field of a byte or bit opcode to a data-space address.
// Purely combinational; assumes the caller registers the result.
module addr_resolve (
    input wire logic [ilo_pkg::DATA_W-1:0] file_i,
    input wire logic access_sel_i,
    input wire logic ext_en_i,
    input wire logic [ilo_pkg::ADDR_W-1:0] fsr_i,
    input wire logic [ilo_pkg::BANK_W-1:0] bank_sel_i,
    output logic [ilo_pkg::ADDR_W-1:0] addr_o,
    output logic indexed_o
);
    import ilo_pkg::*;

    logic [ADDR_W-1:0] sum;

    always_comb begin
        sum = fsr_i + {{(ADDR_W-DATA_W){1'b0}}, file_i};
        indexed_o = 1'b0;
        if (access_sel_i) begin
            addr_o = {bank_sel_i, file_i};
        end else if (ext_en_i && (file_i <= OFFSET_MAX)) begin
            indexed_o = 1'b1;
            addr_o = sum;
        end else if (file_i <= OFFSET_MAX) begin
            addr_o = {ACCESS_LO_BANK, file_i};
        end else begin
            addr_o = {ACCESS_HI_BANK, file_i};
        end
    end
endmodule

// >>> verilog/ilo_decode.sv
// Operand decode and execution of byte and bit opcodes with optional indexed offsets.
// Assumes a data memory that returns read data one cycle after its read enable.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.

module ilo_decode (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic instr_valid_i,
    input wire logic [ilo_pkg::INSTR_W-1:0] instr_i,
    output logic busy_o,
    output logic done_o,
    output logic indexed_o,
    output logic mem_rd_en_o,
    output logic [ilo_pkg::ADDR_W-1:0] mem_rd_addr_o,
    input wire logic [ilo_pkg::DATA_W-1:0] mem_rd_data_i,
    output logic mem_wr_en_o,
    output logic [ilo_pkg::ADDR_W-1:0] mem_wr_addr_o,
    output logic [ilo_pkg::DATA_W-1:0] mem_wr_data_o,
    input wire logic [ilo_pkg::REG_ADDR_W-1:0] reg_addr_i,
    input wire logic [ilo_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [ilo_pkg::DATA_W-1:0] reg_rdata_o
);
    import ilo_pkg::*;

    typedef struct packed {
        state_t state;
        logic [INSTR_W-1:0] instr;
        logic [ADDR_W-1:0] ea;
        logic indexed;
        logic ext_en;
        logic [ADDR_W-1:0] fsr;
        logic [BANK_W-1:0] bank_sel;
        logic [DATA_W-1:0] work;
        logic [FLAG_W-1:0] flags;
        logic rd_en;
        logic wr_en;
        logic [DATA_W-1:0] wr_data;
        logic done;
        logic [DATA_W-1:0] rdata;
    } core_t;

    // Power-on contents: idle, extension off, pointer and bank at zero.
    localparam core_t CORE_RESET = '{
        state: ST_IDLE,
        instr: '0,
        ea: '0,
        indexed: 1'b0,
        ext_en: EXT_EN_RESET,
        fsr: FSR_RESET,
        bank_sel: BANK_SEL_RESET,
        work: WORK_RESET,
        flags: FLAGS_RESET,
        rd_en: 1'b0,
        wr_en: 1'b0,
        wr_data: '0,
        done: 1'b0,
        rdata: '0
    };

    core_t cur_ff;
    core_t nxt_cur;
    logic [ADDR_W-1:0] res_addr;
    logic res_indexed;

    // The resolver serves every opcode, whatever its operation.
    addr_resolve u_resolve (
        .file_i(instr_i[DATA_W-1:0]),
        .access_sel_i(instr_i[A_BIT]),
        .ext_en_i(cur_ff.ext_en),
        .fsr_i(cur_ff.fsr),
        .bank_sel_i(cur_ff.bank_sel),
        .addr_o(res_addr),
        .indexed_o(res_indexed)
    );

    logic [DATA_W:0] sum;
    logic [NIBBLE_W:0] low_sum;
    logic [DATA_W-1:0] result;
    logic is_add;
    logic is_bset;
    logic is_set;
    logic [BIT_IDX_W-1:0] bit_idx;

    // Add results, worked out apart from the state update so that they read plainly.
    logic add_carry;
    logic add_digit_carry;
    logic add_zero;
    logic add_negative;
    logic add_overflow;

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.rd_en = 1'b0;
        nxt_cur.wr_en = 1'b0;
        nxt_cur.done = 1'b0;
        nxt_cur.rdata = '0;
        is_add = (cur_ff.instr[INSTR_W-1:OPC_ADD_LSB] == OPC_ADD_WORK_MEM);
        is_bset = (cur_ff.instr[INSTR_W-1:OPC_BSET_LSB] == OPC_MEM_BIT_SET);
        is_set = (cur_ff.instr[INSTR_W-1:OPC_SET_LSB] == OPC_MEM_SET_ONES);
        bit_idx = cur_ff.instr[BIT_IDX_LSB+BIT_IDX_W-1:BIT_IDX_LSB];
        sum = {1'b0, cur_ff.work} + {1'b0, mem_rd_data_i};
        low_sum = {1'b0, cur_ff.work[NIBBLE_W-1:0]} + {1'b0, mem_rd_data_i[NIBBLE_W-1:0]};
        result = mem_rd_data_i;

        // Overflow is two operands of one sign giving a sum of the other sign.
        add_carry = sum[DATA_W];
        add_digit_carry = low_sum[NIBBLE_W];
        add_zero = (sum[DATA_W-1:0] == '0);
        add_negative = sum[DATA_W-1];
        add_overflow = (cur_ff.work[DATA_W-1] == mem_rd_data_i[DATA_W-1])
            && (sum[DATA_W-1] != cur_ff.work[DATA_W-1]);

        // Software register writes; hardware results below take precedence.
        if (reg_wr_i) begin
            if (reg_addr_i == REG_CFG) begin
                nxt_cur.ext_en = reg_wdata_i[CFG_EXT_BIT];
            end else if (reg_addr_i == REG_FSR_LO) begin
                nxt_cur.fsr[DATA_W-1:0] = reg_wdata_i;
            end else if (reg_addr_i == REG_FSR_HI) begin
                nxt_cur.fsr[ADDR_W-1:DATA_W] = reg_wdata_i[ADDR_W-DATA_W-1:0];
            end else if (reg_addr_i == REG_BANK_SEL) begin
                nxt_cur.bank_sel = reg_wdata_i[BANK_W-1:0];
            end else if (reg_addr_i == REG_WORK) begin
                nxt_cur.work = reg_wdata_i;
            end else if (reg_addr_i == REG_STATUS) begin
                nxt_cur.flags = reg_wdata_i[FLAG_W-1:0];
            end
        end

        if (reg_rd_i) begin
            if (reg_addr_i == REG_CFG) begin
                nxt_cur.rdata[CFG_EXT_BIT] = cur_ff.ext_en;
            end else if (reg_addr_i == REG_FSR_LO) begin
                nxt_cur.rdata = cur_ff.fsr[DATA_W-1:0];
            end else if (reg_addr_i == REG_FSR_HI) begin
                nxt_cur.rdata = {{(2*DATA_W-ADDR_W){1'b0}}, cur_ff.fsr[ADDR_W-1:DATA_W]};
            end else if (reg_addr_i == REG_BANK_SEL) begin
                nxt_cur.rdata = {{(DATA_W-BANK_W){1'b0}}, cur_ff.bank_sel};
            end else if (reg_addr_i == REG_WORK) begin
                nxt_cur.rdata = cur_ff.work;
            end else if (reg_addr_i == REG_STATUS) begin
                nxt_cur.rdata = {{(DATA_W-FLAG_W){1'b0}}, cur_ff.flags};
            end
        end

        // One instruction takes three clocks: take, memory read, execute.
        case (cur_ff.state)
            ST_IDLE: begin
                // The address uses the pointer and bank as they stand at the take edge.
                if (instr_valid_i) begin
                    nxt_cur.instr = instr_i;
                    nxt_cur.ea = res_addr;
                    nxt_cur.indexed = res_indexed;
                    nxt_cur.rd_en = 1'b1;
                    nxt_cur.state = ST_READ;
                end
            end
            ST_READ: begin
                nxt_cur.state = ST_EXEC;
            end
            ST_EXEC: begin
                // Memory data stand only in this cycle, one after the read strobe.
                // Unknown opcodes still pulse done but change neither memory nor flags.
                nxt_cur.state = ST_IDLE;
                nxt_cur.done = 1'b1;
                if (is_add) begin
                    result = sum[DATA_W-1:0];
                    nxt_cur.flags[FLAG_C] = add_carry;
                    nxt_cur.flags[FLAG_DIGIT_C] = add_digit_carry;
                    nxt_cur.flags[FLAG_Z] = add_zero;
                    nxt_cur.flags[FLAG_N] = add_negative;
                    nxt_cur.flags[FLAG_OVFL] = add_overflow;
                    if (cur_ff.instr[D_BIT]) begin
                        nxt_cur.wr_en = 1'b1;
                    end else begin
                        nxt_cur.work = result;
                    end
                end else if (is_bset) begin
                    result[bit_idx] = 1'b1;
                    nxt_cur.wr_en = 1'b1;
                end else if (is_set) begin
                    result = ALL_ONES;
                    nxt_cur.wr_en = 1'b1;
                end
                nxt_cur.wr_data = result;
            end
            default: begin
                nxt_cur.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cur_ff <= CORE_RESET;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Writes go back to the address that was read, so one register serves both ports.
    assign busy_o = (cur_ff.state != ST_IDLE);
    assign done_o = cur_ff.done;
    assign indexed_o = cur_ff.indexed;
    assign mem_rd_en_o = cur_ff.rd_en;
    assign mem_rd_addr_o = cur_ff.ea;
    assign mem_wr_en_o = cur_ff.wr_en;
    assign mem_wr_addr_o = cur_ff.ea;
    assign mem_wr_data_o = cur_ff.wr_data;
    assign reg_rdata_o = cur_ff.rdata;
endmodule

// >>> test/ilo_props.sv
// Checker for the operand decoder ports.
// Assumes it is bound to ilo_decode in the single core clock domain.
module ilo_props (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic instr_valid_i,
    input wire logic [ilo_pkg::INSTR_W-1:0] instr_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic mem_rd_en_o,
    input wire logic [ilo_pkg::ADDR_W-1:0] mem_rd_addr_o,
    input wire logic mem_wr_en_o,
    input wire logic [ilo_pkg::ADDR_W-1:0] mem_wr_addr_o,
    input wire logic [ilo_pkg::DATA_W-1:0] mem_wr_data_o
);
    import ilo_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire take = instr_valid_i && !busy_o;
    a_take_read: assert property (take |=> mem_rd_en_o && busy_o)
        else $error("read not issued after take");
    a_done_timing: assert property (mem_rd_en_o |-> busy_o ##1 busy_o ##1 done_o && !busy_o)
        else $error("done not two cycles after read");
    a_wr_done: assert property (mem_wr_en_o |-> done_o && mem_wr_addr_o == mem_rd_addr_o)
        else $error("write outside done or at other address");
    a_high_abs: assert property (take && !instr_i[8] && instr_i[7:0] > OFFSET_MAX
        |=> mem_rd_addr_o == {ACCESS_HI_BANK, $past(instr_i[7:0])}) else $error("high field moved");
    a_bank_low: assert property (take && instr_i[8]
        |=> mem_rd_addr_o[7:0] == $past(instr_i[7:0])) else $error("banked field moved");
    a_ones_data: assert property (done_o && $past(instr_i[15:9], 3) == OPC_MEM_SET_ONES
        |-> mem_wr_en_o && mem_wr_data_o == ALL_ONES) else $error("set ones data wrong");
    a_add_work: assert property (done_o && $past(instr_i[15:9], 3) == {OPC_ADD_WORK_MEM, 1'b0}
        |-> !mem_wr_en_o) else $error("add to work wrote memory");
    a_bit_data: assert property (done_o && $past(instr_i[15:12], 3) == OPC_MEM_BIT_SET
        |-> mem_wr_en_o && mem_wr_data_o[$past(instr_i[11:9], 3)]) else $error("bit not set");
    cover property (take && !instr_i[8]);
    cover property (mem_wr_en_o);
    cover property (done_o && !mem_wr_en_o);
endmodule
bind ilo_decode ilo_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .busy_o(busy_o), .done_o(done_o),
    .mem_rd_en_o(mem_rd_en_o), .mem_rd_addr_o(mem_rd_addr_o), .mem_wr_en_o(mem_wr_en_o),
    .mem_wr_addr_o(mem_wr_addr_o), .mem_wr_data_o(mem_wr_data_o));

// >>> test/ilo_mem_model.sv
// Data memory model on the far side of the decoder.
// Assumes read data are wanted exactly one cycle after the read enable.
module ilo_mem_model (
    input wire logic clk_i,
    input wire logic rd_en_i,
    input wire logic [ilo_pkg::ADDR_W-1:0] rd_addr_i,
    input wire logic wr_en_i,
    input wire logic [ilo_pkg::ADDR_W-1:0] wr_addr_i,
    input wire logic [ilo_pkg::DATA_W-1:0] wr_data_i,
    output logic [ilo_pkg::DATA_W-1:0] rd_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import ilo_pkg::*;
    logic [DATA_W-1:0] mem [4096];
    initial begin
        rd_data_o = 8'h00;
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'(i * 37 + 11);
        end
    end
    // Outside the answer cycle the data toggle so a stale byte never passes.
    always @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= rd_en_i ? mem[rd_addr_i] : ~rd_data_o;
    end
endmodule

// >>> test/indexed_offset_address_decode_test.sv
// Self-checking bench for ilo_decode against a data memory model.
// Assumes the fixed three-cycle execution and one-cycle register read latency.
module indexed_offset_address_decode_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ilo_pkg::*;
    logic clk_i = 0, rst_n_i = 0, instr_valid_i = 0, reg_wr_i = 0, reg_rd_i = 0;
    logic [INSTR_W-1:0] instr_i = '0;
    logic [REG_ADDR_W-1:0] reg_addr_i = '0;
    logic [DATA_W-1:0] reg_wdata_i = '0, mem_rd_data_i, mem_wr_data_o, reg_rdata_o;
    logic busy_o, done_o, indexed_o, mem_rd_en_o, mem_wr_en_o;
    logic [ADDR_W-1:0] mem_rd_addr_o, mem_wr_addr_o;
    int fail_count = 0, n_checks = 0, seed = 85;
    int w, fl, m, s, ea, f, a, d, ext, fsr, op, b;
    ilo_decode u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .busy_o(busy_o), .done_o(done_o), .indexed_o(indexed_o),
        .mem_rd_en_o(mem_rd_en_o), .mem_rd_addr_o(mem_rd_addr_o), .mem_rd_data_i(mem_rd_data_i),
        .mem_wr_en_o(mem_wr_en_o), .mem_wr_addr_o(mem_wr_addr_o), .mem_wr_data_o(mem_wr_data_o),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
    ilo_mem_model u_mem (.clk_i(clk_i), .rd_en_i(mem_rd_en_o), .rd_addr_i(mem_rd_addr_o),
        .wr_en_i(mem_wr_en_o), .wr_addr_i(mem_wr_addr_o), .wr_data_i(mem_wr_data_o),
        .rd_data_o(mem_rd_data_i));
    initial forever #20 clk_i = ~clk_i;
    function automatic int rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input int ad, input int v);
        @(posedge clk_i);
        reg_addr_i <= 3'(ad);
        reg_wdata_i <= 8'(v);
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input int ad, input string nm, input int exp);
        @(posedge clk_i);
        reg_addr_i <= 3'(ad);
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(nm, 12'(exp), {4'h0, reg_rdata_o});
        @(posedge clk_i);
        #1;
        chk({nm, " after"}, 12'h000, {4'h0, reg_rdata_o});
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(REG_CFG, "ext", 0);
        rd(REG_FSR_LO, "pointer", 0);
        rd(3'h6, "unmapped", 0);
        fl = 0;
        $display("reset test done");
        for (int i = 0; i < 60; i++) begin
            ext = (i < 6) ? 0 : rnd() & 1;
            fsr = (i % 5 == 0) ? 0 : (i % 5 == 1) ? 12'hFF0 : rnd() & 12'hFFF;
            f = (i % 3 == 0) ? 95 + (i & 1) : rnd() & 255;
            {a, d, b, op, w} = {rnd() & 1, rnd() & 1, rnd() & 7, i % 3, rnd() & 255};
            wr(REG_CFG, ext);
            wr(REG_FSR_LO, fsr);
            wr(REG_FSR_HI, fsr >> 8);
            wr(REG_BANK_SEL, i % 16);
            wr(REG_WORK, w);
            ea = a ? (i % 16) * 256 + f : (ext && f <= 95) ? (fsr + f) % 4096 : f < 96 ? f : 3840 + f;
            m = u_mem.mem[ea];
            @(posedge clk_i);
            instr_i <= (op == 0) ? {OPC_ADD_WORK_MEM, 1'(d), 1'(a), 8'(f)} : (op == 1) ?
                {OPC_MEM_BIT_SET, 3'(b), 1'(a), 8'(f)} : {OPC_MEM_SET_ONES, 1'(a), 8'(f)};
            instr_valid_i <= 1'b1;
            @(posedge clk_i);
            instr_valid_i <= 1'b0;
            for (int k = 0; done_o !== 1'b1; k++) begin
                if (k == 8) begin
                    fail_count++;
                    give_verdict();
                end
                @(posedge clk_i);
                #1;
            end
            s = (op == 0) ? w + m : (op == 1) ? (m | (1 << b)) : 255;
            if (op == 0) begin
                fl = ((s & 255) == 0 ? 4 : 0) + (s >> 8) + (((w & 15) + (m & 15)) >> 4) * 2
                    + (s & 128) / 8 + (((w ^ s) & (m ^ s) & 128) >> 4);
            end
            chk("indexed", a == 0 && ext == 1 && f <= 95, indexed_o);
            chk("address", ea, mem_rd_addr_o);
            chk("write enable", op != 0 || d == 1, mem_wr_en_o);
            if (op != 0 || d == 1) begin
                chk("write data", s & 255, mem_wr_data_o);
            end else begin
                w = s & 255;
            end
            rd(REG_WORK, "work", w);
            rd(REG_STATUS, "flags", fl);
            $display("instruction test %0d done", i);
        end
        give_verdict();
    end
endmodule
